// ---- inc/mfp_pkg.sv ----
// Summary of operation
// R01 - mode strap sampled at reset release picks host setup and initial pin states
// R02 - strap 011 spi slave, 100 9-bit serial slave, 101 type-b bus, rest test
// R03 - pin 0 is slave select in straps 001-100, else gpio/irq/pwm/reserved
// R04 - pin 1 is slave clock in straps 001-100, else gpio/irq/clock out/reserved
// R05 - pin 2 is slave data in in straps 001-100, else gpio/irq/tearing/reserved
// R06 - pin 3 gives bypassed slave select in serial mode, else master select
// R07 - pin 3 otherwise gpio, clock out, line end pulse or reserved
// R08 - pin 4 master clock when master enabled, else gpio/pwm/data enable/reserved
// R09 - pin 5 master data io when master enabled, else gpio or irq
// R10 - pin 6 in serial modes: bypass select, or slave data out in 4-wire
// R11 - pin 6 otherwise second master select, master data in, irq, pwm, te, gpio
// R12 - pin 6 leaves reset as input with pull-down on
// R13 - i2c master: clock open-drain out, data open-drain io, released after reset
// R14 - dsi lane 0 two-way, lanes 1, 2 and clock lane transmit only
// R15 - standby low floats every pin except pin 6, which keeps its pull-down
// R16 - reserved function codes leave the pin an undriven input
package mfp_pkg;
    localparam int PIN_N = 7;
    localparam int SYNC_W = 13;
    localparam int GP0 = 0;
    localparam int GP1 = 1;
    localparam int GP2 = 2;
    localparam int GP3 = 3;
    localparam int GP4 = 4;
    localparam int GP5 = 5;
    localparam int GP6 = 6;

    localparam logic [2:0] STRAP_T1    = 3'h1;
    localparam logic [2:0] STRAP_T2    = 3'h2;
    localparam logic [2:0] STRAP_SPI   = 3'h3;
    localparam logic [2:0] STRAP_SSI   = 3'h4;
    localparam logic [2:0] STRAP_TYPEB = 3'h5;

    localparam logic [3:0] CFG_NONE  = 4'h0;
    localparam logic [3:0] CFG_SPI   = 4'h1;
    localparam logic [3:0] CFG_SSI   = 4'h2;
    localparam logic [3:0] CFG_TYPEB = 4'h4;
    localparam logic [3:0] CFG_TEST  = 4'h8;

    localparam logic [1:0] FS_C00 = 2'h0;
    localparam logic [1:0] FS_C01 = 2'h1;
    localparam logic [1:0] FS_C10 = 2'h2;
    localparam logic [1:0] FS_C11 = 2'h3;
    localparam logic       FS1_IRQ = 1'h1;

    localparam logic [6:0] PIN_OFF  = 7'h00;
    localparam logic [6:0] PD_RESET = 7'h40;
    localparam logic [6:0] PD_TYPEB = 7'h45;
    localparam logic [2:0] DSI_TX_ONLY = 3'h7;
    localparam logic [3:0] DSI_OFF  = 4'h0;
    localparam logic       SCS_IDLE = 1'h1;
    localparam logic       OD_LOW   = 1'h0;

    typedef enum logic [12:0] {
        MFP_IN    = 13'h0001,
        MFP_GPIO  = 13'h0002,
        MFP_IRQ   = 13'h0004,
        MFP_PWM   = 13'h0008,
        MFP_CLKO  = 13'h0010,
        MFP_LEND  = 13'h0020,
        MFP_HDE   = 13'h0040,
        MFP_MSEL  = 13'h0080,
        MFP_MSEL2 = 13'h0100,
        MFP_MCLK  = 13'h0200,
        MFP_MDIO  = 13'h0400,
        MFP_BYP   = 13'h0800,
        MFP_SDO   = 13'h1000
    } mfp_role_t;

    function automatic logic mfp_is_slave(input logic [2:0] s);
        return (s == STRAP_T1) || (s == STRAP_T2) || (s == STRAP_SPI) || (s == STRAP_SSI);
    endfunction : mfp_is_slave
endpackage : mfp_pkg

// ---- inc/mfp_pin_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface mfp_pin_if #(parameter int N = mfp_pkg::PIN_N);
    mfp_pkg::mfp_role_t role [N];
    logic [N-1:0]       gpio_out;
    logic [N-1:0]       gpio_oe;
    logic [N-1:0]       pd_req;
    logic               irq;
    logic               pwm;
    logic               clko;
    logic               lend;
    logic               host_data_enable_out;
    logic               msel;
    logic               msel2;
    logic               mclk;
    logic               mdo;
    logic               mdo_oe;
    logic               bypass;
    logic               sdo;
    logic               standby;
    modport ctl (output role, gpio_out, gpio_oe, pd_req, irq, pwm, clko, lend, host_data_enable_out,
                 msel, msel2, mclk, mdo, mdo_oe, bypass, sdo, standby);
    modport pad (input role, gpio_out, gpio_oe, pd_req, irq, pwm, clko, lend, host_data_enable_out,
                 msel, msel2, mclk, mdo, mdo_oe, bypass, sdo, standby);
endinterface : mfp_pin_if
`default_nettype wire

// ---- hw/mfp_pad_stage.sv ----
`timescale 1ns/100ps
`default_nettype none
module mfp_pad_stage #(
    parameter int N = mfp_pkg::PIN_N
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst_n,
    mfp_pin_if.pad      bus,
    output logic [N-1:0] o_out,
    output logic [N-1:0] o_oe,
    output logic [N-1:0] o_pd
);
    import mfp_pkg::*;

    // ****************************************
    // per pin driver select and pad flops
    // ****************************************
    for (genvar i = 0; i < N; i++) begin : g_pin
        logic d_out;
        logic d_oe;
        logic drive;
        logic q_out;
        logic q_oe;
        logic q_pd;
        always_comb begin
            d_out = 1'h0;
            d_oe  = 1'h0;
            unique case (bus.role[i])
                MFP_IN:    d_oe = 1'h0; // R16
                MFP_GPIO:  begin d_out = bus.gpio_out[i]; d_oe = bus.gpio_oe[i]; end
                MFP_IRQ:   begin d_out = bus.irq;    d_oe = 1'h1; end
                MFP_PWM:   begin d_out = bus.pwm;    d_oe = 1'h1; end
                MFP_CLKO:  begin d_out = bus.clko;   d_oe = 1'h1; end
                MFP_LEND:  begin d_out = bus.lend;   d_oe = 1'h1; end
                MFP_HDE:   begin d_out = bus.host_data_enable_out;    d_oe = 1'h1; end
                MFP_MSEL:  begin d_out = bus.msel;   d_oe = 1'h1; end
                MFP_MSEL2: begin d_out = bus.msel2;  d_oe = 1'h1; end
                MFP_MCLK:  begin d_out = bus.mclk;   d_oe = 1'h1; end
                MFP_MDIO:  begin d_out = bus.mdo;    d_oe = bus.mdo_oe; end
                MFP_BYP:   begin d_out = bus.bypass; d_oe = 1'h1; end
                MFP_SDO:   begin d_out = bus.sdo;    d_oe = 1'h1; end
                default:   d_oe = 1'h0;
            endcase
        end
        // standby wins over every role
        assign drive = d_oe && !bus.standby; // R15
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                q_out <= 1'h0;
                q_oe  <= 1'h0;
                q_pd  <= PD_RESET[i]; // R12
            end else begin
                q_out <= d_out;
                q_oe  <= drive;
                q_pd  <= bus.pd_req[i] && !drive;
            end
        end
        assign o_out[i] = q_out;
        assign o_oe[i]  = q_oe;
        assign o_pd[i]  = q_pd;
    end
endmodule : mfp_pad_stage
`default_nettype wire

// ---- hw/mfp_pin_selector.sv ----
`timescale 1ns/100ps
`default_nettype none
module mfp_pin_selector (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [2:0]  i_mode_strap,
    input  wire logic        i_standby_pin_n,
    input  wire logic [6:0]  i_pin_in,
    input  wire logic        i_scl_in,
    input  wire logic        i_sda_in,
    input  wire logic        i_master_en,
    input  wire logic        i_bypass_en,
    input  wire logic        i_slave_4wire,
    input  wire logic        i_cs2_pin_sel,
    input  wire logic [1:0]  i_fsel_pin0,
    input  wire logic [1:0]  i_fsel_pin1,
    input  wire logic [1:0]  i_fsel_pin2,
    input  wire logic [1:0]  i_fsel_pin3,
    input  wire logic [1:0]  i_fsel_pin4,
    input  wire logic        i_fsel_pin5,
    input  wire logic [1:0]  i_fsel_pin6,
    input  wire logic [6:0]  i_gpio_out,
    input  wire logic [6:0]  i_gpio_oe,
    input  wire logic        i_irq,
    input  wire logic        i_pwm,
    input  wire logic        i_clock_output_src,
    input  wire logic        i_line_end_pulse,
    input  wire logic        i_host_data_enable_out,
    input  wire logic        i_master_serial_select,
    input  wire logic        i_master_serial_select_second,
    input  wire logic        i_master_serial_clock,
    input  wire logic        i_master_serial_data_out,
    input  wire logic        i_master_serial_data_oe,
    input  wire logic        i_slave_serial_data_out,
    input  wire logic        i_i2c_scl_low,
    input  wire logic        i_i2c_sda_low,
    input  wire logic        i_dsi_lane0_tx,
    output logic [6:0]       o_pin_out,
    output logic [6:0]       o_pin_oe,
    output logic [6:0]       o_pin_pd,
    output logic [6:0]       o_pin_in,
    output logic             o_slave_serial_select,
    output logic             o_slave_serial_clock,
    output logic             o_slave_serial_data_in,
    output logic             o_tearing_effect_signal,
    output logic             o_master_serial_data_in,
    output logic             o_master_serial_data_io_in,
    output logic             o_scl_out,
    output logic             o_scl_oe,
    output logic             o_sda_out,
    output logic             o_sda_oe,
    output logic             o_i2c_scl_in,
    output logic             o_i2c_sda_in,
    output logic [3:0]       o_dsi_lane_oe,
    output logic [3:0]       o_host_cfg,
    output logic             o_strap_valid
);
    import mfp_pkg::*;

    // ****************************************
    // reset release and input synchronisers
    // ****************************************
    logic [1:0]        rst_sync;
    logic              rst_n;
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [2:0]        strap_s;
    logic              standby_n_s;
    logic              scl_s;
    logic              sda_s;
    logic [6:0]        pin_s;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) rst_sync <= 2'h0;
        else rst_sync <= {rst_sync[0], 1'h1};
    end
    assign rst_n = rst_sync[1];

    // raw reset here so the strap is settled when rst_n rises
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {i_mode_strap, i_standby_pin_n, i_scl_in, i_sda_in, i_pin_in};
            sync2 <= sync1;
        end
    end
    assign {strap_s, standby_n_s, scl_s, sda_s, pin_s} = sync2;

    // ****************************************
    // strap capture
    // ****************************************
    logic       cap_valid;
    logic [2:0] strap_cap;
    logic       standby;
    logic       slave;
    logic       master;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_valid <= 1'h0;
            strap_cap <= 3'h0;
        end else if (!cap_valid) begin
            cap_valid <= 1'h1;
            strap_cap <= strap_s; // R01
        end
    end

    assign standby = !standby_n_s;
    assign slave   = cap_valid && mfp_is_slave(strap_cap); // R03 R04 R05
    assign master  = cap_valid && i_master_en;

    // ****************************************
    // function field decode
    // ****************************************
    function automatic mfp_role_t role_of(input logic [1:0] f, input mfp_role_t r01,
                                         input mfp_role_t r10, input mfp_role_t r11);
        unique case (f)
            FS_C00: return MFP_GPIO;
            FS_C01: return r01;
            FS_C10: return r10;
            default: return r11;
        endcase
    endfunction : role_of

    function automatic logic [3:0] cfg_of(input logic [2:0] s);
        unique case (s)
            STRAP_SPI:   return CFG_SPI;
            STRAP_SSI:   return CFG_SSI;
            STRAP_TYPEB: return CFG_TYPEB;
            default:     return CFG_TEST;
        endcase
    endfunction : cfg_of

    mfp_role_t dec [PIN_N];
    mfp_pin_if #(.N(PIN_N)) pins ();

    assign dec[GP0] = slave ? MFP_IN : role_of(i_fsel_pin0, MFP_IRQ, MFP_PWM, MFP_IN); // R03 R16
    assign dec[GP1] = slave ? MFP_IN : role_of(i_fsel_pin1, MFP_IRQ, MFP_CLKO, MFP_IN); // R04
    assign dec[GP2] = slave ? MFP_IN : role_of(i_fsel_pin2, MFP_IRQ, MFP_IN, MFP_IN); // R05
    assign dec[GP3] = (slave && i_bypass_en) ? MFP_BYP : // R06
                      master ? MFP_MSEL : role_of(i_fsel_pin3, MFP_CLKO, MFP_LEND, MFP_IN); // R07
    assign dec[GP4] = master ? MFP_MCLK : role_of(i_fsel_pin4, MFP_PWM, MFP_HDE, MFP_IN); // R08
    assign dec[GP5] = master ? MFP_MDIO : (i_fsel_pin5 == FS1_IRQ) ? MFP_IRQ : MFP_GPIO; // R09
    assign dec[GP6] = slave ? (i_slave_4wire ? MFP_SDO : i_bypass_en ? MFP_BYP : MFP_IN) : // R10
                      master ? (i_cs2_pin_sel ? MFP_MSEL2 : MFP_IN) : // R11
                      role_of(i_fsel_pin6, MFP_IN, MFP_PWM, MFP_IRQ);

    // nothing drives until the strap is known
    for (genvar i = 0; i < PIN_N; i++) begin : g_role
        assign pins.role[i] = cap_valid ? dec[i] : MFP_IN; // R01
    end

    // ****************************************
    // sources handed to the pad stage
    // ****************************************
    assign pins.gpio_out = i_gpio_out;
    assign pins.gpio_oe  = i_gpio_oe;
    assign pins.irq      = i_irq;
    assign pins.pwm      = i_pwm;
    assign pins.clko     = i_clock_output_src;
    assign pins.lend     = i_line_end_pulse;
    assign pins.host_data_enable_out      = i_host_data_enable_out;
    assign pins.msel     = i_master_serial_select;
    assign pins.msel2    = i_master_serial_select_second;
    assign pins.mclk     = i_master_serial_clock;
    assign pins.mdo      = i_master_serial_data_out;
    assign pins.mdo_oe   = i_master_serial_data_oe;
    assign pins.bypass   = pin_s[GP0]; // R06
    assign pins.sdo      = i_slave_serial_data_out;
    assign pins.standby  = standby;
    // pull-downs drop in standby except on pin 6
    assign pins.pd_req   = (standby || !cap_valid) ? PD_RESET : // R12 R15
                           (strap_cap == STRAP_TYPEB) ? PD_TYPEB : PD_RESET; // R01

    mfp_pad_stage #(.N(PIN_N)) u_pads (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .bus     (pins.pad),
        .o_out   (o_pin_out),
        .o_oe    (o_pin_oe),
        .o_pd    (o_pin_pd)
    );

    // ****************************************
    // input routing back to the core
    // ****************************************
    logic next_scs;
    logic next_sck;
    logic next_sdi;
    logic next_te;
    logic next_mdi;
    logic next_mdio;
    logic te_p2;
    logic te_p6;

    assign next_scs  = slave ? pin_s[GP0] : SCS_IDLE;
    assign next_sck  = slave && pin_s[GP1];
    assign next_sdi  = slave && pin_s[GP2];
    assign te_p2     = cap_valid && !slave && (i_fsel_pin2 == FS_C10);
    assign te_p6     = cap_valid && !slave && !master && (i_fsel_pin6 == FS_C01);
    assign next_te   = te_p2 ? pin_s[GP2] : te_p6 && pin_s[GP6]; // R05 R11
    assign next_mdi  = master && !slave && !i_cs2_pin_sel && pin_s[GP6]; // R11
    assign next_mdio = master && pin_s[GP5];

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_slave_serial_select      <= SCS_IDLE;
            o_slave_serial_clock       <= 1'h0;
            o_slave_serial_data_in     <= 1'h0;
            o_tearing_effect_signal    <= 1'h0;
            o_master_serial_data_in    <= 1'h0;
            o_master_serial_data_io_in <= 1'h0;
            o_pin_in                   <= PIN_OFF;
        end else begin
            o_slave_serial_select      <= next_scs;
            o_slave_serial_clock       <= next_sck;
            o_slave_serial_data_in     <= next_sdi;
            o_tearing_effect_signal    <= next_te;
            o_master_serial_data_in    <= next_mdi;
            o_master_serial_data_io_in <= next_mdio;
            o_pin_in                   <= pin_s;
        end
    end

    // ****************************************
    // i2c, dsi directions and host setup
    // ****************************************
    logic [3:0] next_dsi_oe;
    logic [3:0] next_cfg;

    assign next_dsi_oe = standby ? DSI_OFF : {DSI_TX_ONLY, i_dsi_lane0_tx}; // R14 R15
    assign next_cfg    = cap_valid ? cfg_of(strap_cap) : CFG_NONE; // R02

    // open-drain: only the enable moves, the level stays low
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_scl_out     <= OD_LOW;
            o_sda_out     <= OD_LOW;
            o_scl_oe      <= 1'h0; // R13
            o_sda_oe      <= 1'h0;
            o_i2c_scl_in  <= 1'h1;
            o_i2c_sda_in  <= 1'h1;
            o_dsi_lane_oe <= DSI_OFF;
            o_host_cfg    <= CFG_NONE;
            o_strap_valid <= 1'h0;
        end else begin
            o_scl_out     <= OD_LOW;
            o_sda_out     <= OD_LOW;
            o_scl_oe      <= i_i2c_scl_low && !standby; // R13 R15
            o_sda_oe      <= i_i2c_sda_low && !standby;
            o_i2c_scl_in  <= scl_s;
            o_i2c_sda_in  <= sda_s;
            o_dsi_lane_oe <= next_dsi_oe;
            o_host_cfg    <= next_cfg;
            o_strap_valid <= cap_valid;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    a_strap_hold: assert property (cap_valid |=> $stable(strap_cap) && cap_valid) // R01
        else $error("strap changed after capture");
    a_mode_decode: assert property (cap_valid && strap_cap == STRAP_SSI |=> o_host_cfg == CFG_SSI) // R02
        else $error("ssi strap not decoded");
    a_p0_slave_in: assert property (slave |=> !o_pin_oe[GP0] && !o_pin_oe[GP1] && !o_pin_oe[GP2]) // R03
        else $error("slave input pin driven");
    a_p0_irq_out: assert property (cap_valid && !slave && !standby && i_fsel_pin0 == FS_C01 // R03
        |=> o_pin_oe[GP0] && o_pin_out[GP0] == $past(i_irq))
        else $error("pin 0 irq not driven");
    a_p1_clock_out: assert property (cap_valid && !slave && !standby && i_fsel_pin1 == FS_C10 // R04
        |=> o_pin_oe[GP1] && o_pin_out[GP1] == $past(i_clock_output_src))
        else $error("pin 1 clock out wrong");
    a_p2_tearing_in: assert property (cap_valid && !slave && i_fsel_pin2 == FS_C10 // R05
        |=> !o_pin_oe[GP2] && o_tearing_effect_signal == $past(pin_s[GP2]))
        else $error("pin 2 tearing input wrong");
    a_p3_bypass: assert property (slave && i_bypass_en && !standby // R06
        |=> o_pin_oe[GP3] && o_pin_out[GP3] == $past(pin_s[GP0]))
        else $error("pin 3 bypass select wrong");
    a_p3_line_end: assert property (cap_valid && !slave && !master && !standby
        && i_fsel_pin3 == FS_C10 |=> o_pin_oe[GP3] && o_pin_out[GP3] == $past(i_line_end_pulse)) // R07
        else $error("pin 3 line end wrong");
    a_p4_master_clk: assert property (master && !standby // R08
        |=> o_pin_oe[GP4] && o_pin_out[GP4] == $past(i_master_serial_clock))
        else $error("pin 4 master clock wrong");
    a_p5_master_io: assert property (master && !standby // R09
        |=> o_pin_oe[GP5] == $past(i_master_serial_data_oe))
        else $error("pin 5 data direction wrong");
    a_p6_slave_out: assert property (slave && i_slave_4wire && !standby // R10
        |=> o_pin_oe[GP6] && o_pin_out[GP6] == $past(i_slave_serial_data_out))
        else $error("pin 6 slave data out wrong");
    a_p6_second_sel: assert property (master && !slave && i_cs2_pin_sel && !standby // R11
        |=> o_pin_oe[GP6] && o_pin_out[GP6] == $past(i_master_serial_select_second))
        else $error("pin 6 second select wrong");
    a_p6_pull_down: assert property (!o_pin_oe[GP6] |-> o_pin_pd[GP6]) // R12
        else $error("pin 6 floats without pull-down");
    a_i2c_open_drain: assert property (!standby |=> o_scl_oe == $past(i_i2c_scl_low) // R13
        && o_sda_oe == $past(i_i2c_sda_low) && !o_scl_out && !o_sda_out)
        else $error("i2c not open-drain");
    a_dsi_lanes: assert property (!standby |=> o_dsi_lane_oe == $past({DSI_TX_ONLY, i_dsi_lane0_tx})) // R14
        else $error("dsi lane direction wrong");
    a_standby_float: assert property (standby |=> o_pin_oe == PIN_OFF && !o_scl_oe && !o_sda_oe // R15
        && o_dsi_lane_oe == DSI_OFF && o_pin_pd[GP6])
        else $error("pin driven in standby");
    a_reserved_input: assert property (cap_valid && !slave && i_fsel_pin0 == FS_C11 // R16
        |=> !o_pin_oe[GP0])
        else $error("reserved code drives pin 0");

    c_slave_mode: cover property (slave && !standby && i_slave_4wire);
    c_master_mode: cover property (master && !slave && !standby);
    c_typeb_mode: cover property (cap_valid && strap_cap == STRAP_TYPEB);
    c_standby_exit: cover property (standby ##1 !standby);
endmodule : mfp_pin_selector
`default_nettype wire

// ---- verif/mfp_pad_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module mfp_pad_model (
    input  wire logic       i_clk,
    input  wire logic [6:0] i_out,
    input  wire logic [6:0] i_oe,
    input  wire logic [6:0] i_pd,
    input  wire logic [6:0] i_host_oe,
    input  wire logic [6:0] i_host_val,
    input  wire logic       i_scl_oe,
    input  wire logic       i_sda_oe,
    output logic [6:0]      o_pin,
    output logic            o_scl,
    output logic            o_sda
);
    // ****
    // pad levels
    // ****
    logic flip = 1'b0;
    always @(posedge i_clk) begin
        flip <= ~flip;
    end
    // an undriven pad without pull-down wanders, so a lost pull-down shows
    always_comb begin
        for (int k = 0; k < 7; k++) begin
            if (i_host_oe[k]) o_pin[k] = i_host_val[k];
            else if (i_oe[k]) o_pin[k] = i_out[k];
            else if (i_pd[k]) o_pin[k] = 1'b0;
            else o_pin[k] = flip ^ k[0];
        end
    end
    assign o_scl = ~i_scl_oe;
    assign o_sda = ~i_sda_oe;
endmodule : mfp_pad_model
`default_nettype wire

// ---- verif/test_multi_function_pin_selector.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, got, ex) begin total_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end
module test_multi_function_pin_selector;
    import mfp_pkg::*;
    // ****
    // stimulus and expectation
    // ****
    logic       i_clk = 1'b0, i_reset_n = 1'b0, i_standby_pin_n = 1'b1, i_scl_in, i_sda_in, i_fsel_pin5;
    logic [2:0] i_mode_strap = 3'h5;
    logic [6:0] i_pin_in, i_gpio_out, i_gpio_oe, host_oe = 7'h00, host_val = 7'h00;
    logic [1:0] i_fsel_pin0, i_fsel_pin1, i_fsel_pin2, i_fsel_pin3, i_fsel_pin4, i_fsel_pin6;
    logic i_master_en, i_bypass_en, i_slave_4wire, i_cs2_pin_sel, i_irq, i_pwm, i_clock_output_src;
    logic i_line_end_pulse, i_host_data_enable_out, i_master_serial_select, i_master_serial_select_second;
    logic i_master_serial_clock, i_master_serial_data_out, i_master_serial_data_oe, i_slave_serial_data_out;
    logic i_i2c_scl_low, i_i2c_sda_low, i_dsi_lane0_tx, o_slave_serial_select, o_slave_serial_clock;
    logic o_slave_serial_data_in, o_tearing_effect_signal, o_master_serial_data_in, o_master_serial_data_io_in;
    logic o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_i2c_scl_in, o_i2c_sda_in, o_strap_valid;
    logic [6:0] o_pin_out, o_pin_oe, o_pin_pd, o_pin_in;
    logic [3:0] o_dsi_lane_oe, o_host_cfg;
    int         err_count = 0, total_checks = 0, seed = 32'h19d2c251;

    mfp_pin_selector u_mfp_pin_selector (.*);
    mfp_pad_model u_mfp_pad_model (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pd(o_pin_pd),
        .i_host_oe(host_oe), .i_host_val(host_val), .i_scl_oe(o_scl_oe), .i_sda_oe(o_sda_oe),
        .o_pin(i_pin_in), .o_scl(i_scl_in), .o_sda(i_sda_in));

    initial begin
        forever #20 i_clk = ~i_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick

    task automatic shake();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        {i_master_en, i_bypass_en, i_slave_4wire, i_cs2_pin_sel, i_fsel_pin5} <= r[4:0];
        {i_fsel_pin0, i_fsel_pin1, i_fsel_pin2, i_fsel_pin3, i_fsel_pin4, i_fsel_pin6} <= r[16:5];
        {i_gpio_out, i_gpio_oe, i_irq, i_pwm, i_clock_output_src, i_line_end_pulse} <= r[34:17];
        {i_host_data_enable_out, i_master_serial_select, i_master_serial_select_second} <= r[37:35];
        {i_master_serial_clock, i_master_serial_data_out, i_master_serial_data_oe} <= r[40:38];
        {i_slave_serial_data_out, i_i2c_scl_low, i_i2c_sda_low, i_dsi_lane0_tx} <= r[44:41];
    endtask : shake

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    task automatic do_reset(input logic [2:0] s);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        i_mode_strap <= s;
        repeat (3) @(posedge i_clk);
        `CHK("rst", {o_pin_oe, o_pin_pd, o_scl_oe, o_host_cfg}, {7'h00, 7'h40, 1'b0, 4'h0})
        i_reset_n <= 1'b1;
        for (int k = 0; k < 10 && o_strap_valid !== 1'b1; k++) tick(1);
        if (o_strap_valid !== 1'b1) begin
            err_count++;
            test_done();
        end
        tick(2);
    endtask : do_reset

    // {oe, driven level} of a pin outside the serial straps
    function automatic logic [1:0] exp_pin(input int p);
        logic [1:0] fs [7];
        logic [1:0] f;
        fs = '{i_fsel_pin0, i_fsel_pin1, i_fsel_pin2, i_fsel_pin3, i_fsel_pin4, {1'b0, i_fsel_pin5}, i_fsel_pin6};
        f = fs[p];
        if (i_master_en && p == 3) return {1'b1, i_master_serial_select};
        if (i_master_en && p == 4) return {1'b1, i_master_serial_clock};
        if (i_master_en && p == 5) return {i_master_serial_data_oe, i_master_serial_data_oe & i_master_serial_data_out};
        if (i_master_en && p == 6) return {i_cs2_pin_sel, i_cs2_pin_sel & i_master_serial_select_second};
        if (f == 2'h0) return {i_gpio_oe[p], i_gpio_oe[p] & i_gpio_out[p]};
        case (p)
            0: return f == 2'h1 ? {1'b1, i_irq} : f == 2'h2 ? {1'b1, i_pwm} : 2'h0;
            1: return f == 2'h1 ? {1'b1, i_irq} : f == 2'h2 ? {1'b1, i_clock_output_src} : 2'h0;
            2: return f == 2'h1 ? {1'b1, i_irq} : 2'h0;
            3: return f == 2'h1 ? {1'b1, i_clock_output_src} : f == 2'h2 ? {1'b1, i_line_end_pulse} : 2'h0;
            4: return f == 2'h1 ? {1'b1, i_pwm} : f == 2'h2 ? {1'b1, i_host_data_enable_out} : 2'h0;
            5: return {1'b1, i_irq};
            default: return f == 2'h3 ? {1'b1, i_irq} : f == 2'h2 ? {1'b1, i_pwm} : 2'h0;
        endcase
    endfunction : exp_pin

    initial begin
        logic [1:0] e;
        logic [6:0] eo;
        shake();
        for (int s = 0; s < 8; s++) begin
            do_reset(s[2:0]);
            `CHK("cfg", o_host_cfg, s == 3 ? 4'h1 : s == 4 ? 4'h2 : s == 5 ? 4'h4 : 4'h8)
        end
        $display("strap test done");
        do_reset(3'h3);
        repeat (40) begin
            @(posedge i_clk);
            shake();
            host_oe <= 7'h07;
            host_val <= 7'($random(seed));
            tick(4);
            `CHK("slv", {o_pin_oe[2:0], o_slave_serial_select, o_slave_serial_clock, o_slave_serial_data_in},
                {3'h0, host_val[0], host_val[1], host_val[2]})
            `CHK("p6", {o_pin_oe[6], o_pin_out[6] & i_slave_4wire},
                {i_slave_4wire | i_bypass_en, i_slave_serial_data_out & i_slave_4wire})
            if (i_bypass_en) `CHK("p3", {o_pin_oe[3], o_pin_out[3]}, {1'b1, host_val[0]})
            `CHK("ins", {o_pin_in[2:0], o_i2c_scl_in, o_i2c_sda_in, o_tearing_effect_signal, o_master_serial_data_in},
                {host_val[2:0], ~i_i2c_scl_low, ~i_i2c_sda_low, 2'h0})
        end
        $display("serial test done");
        host_oe <= 7'h00;
        do_reset(3'h5);
        repeat (200) begin
            @(posedge i_clk);
            shake();
            tick(2);
            for (int p = 0; p < 7; p++) begin
                e = exp_pin(p);
                eo[p] = e[1];
                `CHK("pin", {o_pin_oe[p], o_pin_oe[p] & o_pin_out[p]}, e)
            end
            `CHK("pd", o_pin_pd, ~eo & PD_TYPEB)
            `CHK("i2c", {o_scl_oe, o_sda_oe, o_scl_out, o_sda_out}, {i_i2c_scl_low, i_i2c_sda_low, 2'h0})
            `CHK("dsi", o_dsi_lane_oe, {3'h7, i_dsi_lane0_tx})
        end
        $display("mux test done");
        @(posedge i_clk);
        shake();
        @(posedge i_clk);
        i_standby_pin_n <= 1'b0;
        i_i2c_scl_low <= 1'b1;
        i_gpio_oe <= 7'h7f;
        tick(4);
        `CHK("standby_pin", {o_pin_oe, o_pin_pd, o_scl_oe, o_sda_oe, o_dsi_lane_oe}, {7'h00, 7'h40, 6'h00})
        $display("standby test done");
        test_done();
    end
endmodule : test_multi_function_pin_selector
`default_nettype wire
